// ===== cxm_transceiver.sv
`timescale 1ns/100ps
module cxm_transceiver
  import cxm_pkg::*;
#(
  parameter int MODE_CHG_CYCLES = MODE_CHG_CYC,
  parameter int ACT_CLKS = ACT_CLOCKS
) (
  input wire logic mclk,
  input wire logic reset,
  cxm_if.dev pins,
  input wire logic bus_i,
  output logic bus_o,
  output logic bus_oe,
  input wire logic bus_error,
  output cxm_mode_t mode
);
  if (MODE_CHG_CYCLES < 1 || MODE_CHG_CYCLES >= (1 << CNT_W)) begin
    $error("MODE_CHG_CYCLES out of range");
  end
  if (ACT_CLKS < 1 || ACT_CLKS > 255) begin
    $error("ACT_CLKS out of range");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [SYNC_DEV_W-1:0] raw;
  logic [SYNC_DEV_W-1:0] s1_q;
  logic [SYNC_DEV_W-1:0] s2_q;
  assign raw = {pins.txd, pins.sleep_control_low, pins.role_select, pins.clk_line, bus_i};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= '1;
      s2_q <= '1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic txd_s;
  logic sleep_control_low_s;
  logic slave;
  logic clk_s;
  logic bus_s;
  assign txd_s = s2_q[4];
  assign sleep_control_low_s = s2_q[3];
  assign slave = s2_q[2];
  assign clk_s = s2_q[1];
  assign bus_s = s2_q[0];

  // ****************************************
  // Edge detection and bit timing
  // ****************************************
  logic clk_prev_q;
  logic bus_prev_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clk_prev_q <= 1'b1;
      bus_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= clk_s;
      bus_prev_q <= bus_s;
    end
  end

  logic clk_rise;
  logic ref_fall;
  assign clk_rise = clk_s & ~clk_prev_q;
  // Master times bits on its input clock, slave on bus edges
  assign ref_fall = slave ? (bus_prev_q & ~bus_s) : (clk_prev_q & ~clk_s);

  logic [CNT_W-1:0] ph_q;
  logic [CNT_W-1:0] per_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ph_q <= '1;
      per_q <= '0;
    end else if (ref_fall) begin
      per_q <= ph_q;
      ph_q <= '0;
    end else if (ph_q != '1) begin
      ph_q <= ph_q + 1'b1;
    end
  end

  logic [CNT_W-1:0] short_low;
  logic [CNT_W-1:0] long_low;
  logic [CNT_W-1:0] sample_pt;
  assign short_low = per_q >> 2;
  assign long_low = per_q >> 1;
  assign sample_pt = (per_q >> 2) + (per_q >> 3);

  // ****************************************
  // Encoder and decoder
  // ****************************************
  logic tx_bit_q;
  logic rx_bit_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_bit_q <= 1'b1;
      rx_bit_q <= 1'b1;
    end else begin
      // Controller updates its data after the same clock edge, so take it late
      if (ph_q == CNT_W'(TXD_TAKE_CYC)) begin
        tx_bit_q <= txd_s;
      end
      if (ph_q == sample_pt) begin
        rx_bit_q <= bus_s;
      end
    end
  end

  logic enc_low;
  assign enc_low = ph_q < (tx_bit_q ? short_low : long_low);

  // ****************************************
  // Mode machine
  // ****************************************
  cxm_mode_t mode_q;
  cxm_mode_t mode_d;
  logic [CNT_W-1:0] chg_q;
  logic [7:0] act_q;

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      CXM_SLEEP: begin
        if (sleep_control_low_s) begin
          mode_d = CXM_STANDBY;
        end
      end
      CXM_STANDBY: begin
        if (!sleep_control_low_s || bus_error) begin
          mode_d = CXM_SLEEP;
        end else if (chg_q == CNT_W'(MODE_CHG_CYCLES - 1)) begin
          mode_d = CXM_NORMAL;
        end
      end
      CXM_NORMAL: begin
        if (!sleep_control_low_s || bus_error) begin
          mode_d = CXM_SLEEP;
        end
      end
      default: mode_d = CXM_SLEEP;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_q <= CXM_SLEEP;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      chg_q <= '0;
      act_q <= '0;
    end else if (mode_d != mode_q) begin
      chg_q <= '0;
      act_q <= '0;
    end else begin
      if (mode_q == CXM_STANDBY) begin
        chg_q <= chg_q + 1'b1;
      end
      if (mode_q == CXM_NORMAL && clk_rise && act_q != 8'(ACT_CLKS)) begin
        act_q <= act_q + 1'b1;
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  logic bus_oe_d;
  logic rxd_oe_d;
  logic clk_oe_d;
  logic bus_oe_q;
  logic rxd_oe_q;
  logic clk_oe_q;

  always_comb begin
    bus_oe_d = 1'b0;
    rxd_oe_d = 1'b0;
    clk_oe_d = 1'b0;
    // Follow the next mode so a new mode shows no drive left over from the old one
    unique case (mode_d)
      CXM_NORMAL: begin
        rxd_oe_d = ~rx_bit_q;
        if (slave) begin
          bus_oe_d = ~tx_bit_q & (ph_q < long_low);
          clk_oe_d = ph_q < long_low;
        end else begin
          bus_oe_d = (act_q == 8'(ACT_CLKS)) & enc_low;
        end
      end
      CXM_SLEEP: begin
        if (slave) begin
          // Wake pulse goes out unencoded; received level shows on the clock pin
          bus_oe_d = ~txd_s;
          clk_oe_d = ~bus_s;
        end else begin
          rxd_oe_d = ~bus_s;
        end
      end
      default: begin
        bus_oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      bus_oe_q <= 1'b0;
      rxd_oe_q <= 1'b0;
      clk_oe_q <= 1'b0;
    end else begin
      bus_oe_q <= bus_oe_d;
      rxd_oe_q <= rxd_oe_d;
      clk_oe_q <= clk_oe_d;
    end
  end

  // Gated by the raw pin so the driver drops without synchroniser delay
  assign bus_oe = bus_oe_q & pins.sleep_control_low;
  assign bus_o = 1'b0;
  assign pins.dev_rxd_oe = rxd_oe_q;
  assign pins.dev_clk_oe = clk_oe_q;
  assign mode = mode_q;
endmodule

// ===== cxm_pkg.sv
package cxm_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int MCLK_MHZ = 100;
  // Mode change time, plain default
  localparam int MODE_CHG_US = 100;
  localparam int MODE_CHG_CYC = MODE_CHG_US * MCLK_MHZ;
  // Master bus activation delay, in input clock periods
  localparam int ACT_CLOCKS = 33;
  // Baud clock equals bit rate
  localparam int BAUD_HZ = 20000;
  localparam int BAUD_HALF_CYC = (MCLK_MHZ * 1000000) / BAUD_HZ / 2;
  // Sleep wait time, plain default
  localparam int SLP_WT_US = 100;
  localparam int SLP_WT_CYC = SLP_WT_US * MCLK_MHZ;
  // Cycles after a bit start at which transmit data is taken
  localparam int TXD_TAKE_CYC = 8;
  localparam int CNT_W = 16;
  localparam int UART_BITS = 10;
  localparam int SYNC_DEV_W = 5;
  localparam int SYNC_CTL_W = 2;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0] {
    CXM_SLEEP = 2'b00,
    CXM_STANDBY = 2'b01,
    CXM_NORMAL = 2'b11
  } cxm_mode_t;

  typedef enum logic [1:0] {
    CXM_CTL_OFF = 2'b00,
    CXM_CTL_ON = 2'b01,
    CXM_CTL_STOP = 2'b11
  } cxm_ctl_t;
endpackage

// ===== cxm_if.sv
`timescale 1ns/100ps
interface cxm_if;
  logic txd;
  logic sleep_control_low;
  logic role_select;
  logic dev_rxd_oe;
  logic dev_clk_oe;
  logic ctl_clk_oe;
  logic rxd_line;
  logic clk_line;

  // ****************************************
  // Open-drain lines with pull-up
  // ****************************************
  assign rxd_line = ~dev_rxd_oe;
  assign clk_line = ~(dev_clk_oe | ctl_clk_oe);

  modport dev (
    input txd,
    input sleep_control_low,
    input role_select,
    input clk_line,
    output dev_rxd_oe,
    output dev_clk_oe
  );

  modport ctl (
    output txd,
    output sleep_control_low,
    output role_select,
    output ctl_clk_oe,
    input rxd_line,
    input clk_line
  );
endinterface

// ===== cxm_controller.sv
`timescale 1ns/100ps
module cxm_controller
  import cxm_pkg::*;
#(
  parameter int BAUD_HALF = BAUD_HALF_CYC,
  parameter int SLP_WT_CYCLES = SLP_WT_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  cxm_if.ctl pins,
  input wire logic role_cfg,
  input wire logic supply_ok,
  input wire logic wake_req,
  input wire logic sleep_req,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic awake
);
  if (BAUD_HALF < 16 || BAUD_HALF >= (1 << CNT_W)) begin
    $error("BAUD_HALF out of range");
  end
  if (SLP_WT_CYCLES < 1 || SLP_WT_CYCLES >= (1 << CNT_W)) begin
    $error("SLP_WT_CYCLES out of range");
  end

  // ****************************************
  // Synchronisers and edges
  // ****************************************
  logic [SYNC_CTL_W-1:0] s1_q;
  logic [SYNC_CTL_W-1:0] s2_q;
  logic clk_prev_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= '1;
      s2_q <= '1;
      clk_prev_q <= 1'b1;
    end else begin
      s1_q <= {pins.rxd_line, pins.clk_line};
      s2_q <= s1_q;
      clk_prev_q <= s2_q[0];
    end
  end

  logic bit_fall;
  logic bit_rise;
  assign bit_fall = clk_prev_q & ~s2_q[0];
  assign bit_rise = ~clk_prev_q & s2_q[0];

  // ****************************************
  // Power state
  // ****************************************
  cxm_ctl_t st_q;
  logic role_q;
  logic clk_q;
  logic [CNT_W-1:0] div_q;
  logic [CNT_W-1:0] wt_q;
  logic [3:0] tx_cnt_q;
  logic tx_idle;
  assign tx_idle = (tx_cnt_q == 4'h0);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q <= CXM_CTL_OFF;
      wt_q <= '0;
    end else begin
      unique case (st_q)
        CXM_CTL_OFF: begin
          if (supply_ok && wake_req) begin
            st_q <= CXM_CTL_ON;
          end
        end
        CXM_CTL_ON: begin
          if (sleep_req && tx_idle) begin
            st_q <= CXM_CTL_STOP;
            wt_q <= '0;
          end
        end
        CXM_CTL_STOP: begin
          // Clock is parked high before the wait starts
          if (clk_q || role_q) begin
            if (wt_q == CNT_W'(SLP_WT_CYCLES - 1)) begin
              st_q <= CXM_CTL_OFF;
            end else begin
              wt_q <= wt_q + 1'b1;
            end
          end
        end
        default: st_q <= CXM_CTL_OFF;
      endcase
    end
  end

  // Role only follows its input while asleep and idle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      role_q <= 1'b1;
    end else if (st_q == CXM_CTL_OFF && tx_idle) begin
      role_q <= role_cfg;
    end
  end

  // ****************************************
  // Master baud clock
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clk_q <= 1'b1;
      div_q <= '0;
    end else if (!role_q && (st_q == CXM_CTL_ON || (st_q == CXM_CTL_STOP && !clk_q))) begin
      if (div_q == CNT_W'(BAUD_HALF - 1)) begin
        div_q <= '0;
        clk_q <= ~clk_q;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end else begin
      div_q <= '0;
    end
  end

  // ****************************************
  // UART transmit
  // ****************************************
  logic [UART_BITS-1:0] tx_sh_q;
  logic txd_q;
  assign tx_ready = (st_q == CXM_CTL_ON) & tx_idle & ~sleep_req;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_sh_q <= '1;
      tx_cnt_q <= 4'h0;
      txd_q <= 1'b1;
    end else if (tx_valid && tx_ready) begin
      tx_sh_q <= {1'b1, tx_data, 1'b0};
      tx_cnt_q <= 4'(UART_BITS);
    end else if (bit_fall && !tx_idle) begin
      txd_q <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[UART_BITS-1:1]};
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else if (tx_idle && bit_fall) begin
      txd_q <= 1'b1;
    end
  end

  // ****************************************
  // UART receive
  // ****************************************
  logic [3:0] rx_cnt_q;
  logic [7:0] rx_sh_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (st_q != CXM_CTL_ON) begin
        rx_cnt_q <= 4'h0;
      end else if (bit_rise) begin
        if (rx_cnt_q == 4'h0) begin
          if (!s2_q[1]) begin
            rx_cnt_q <= 4'h9;
          end
        end else if (rx_cnt_q == 4'h1) begin
          rx_cnt_q <= 4'h0;
          if (s2_q[1]) begin
            rx_data <= rx_sh_q;
            rx_valid <= 1'b1;
          end
        end else begin
          rx_sh_q <= {s2_q[1], rx_sh_q[7:1]};
          rx_cnt_q <= rx_cnt_q - 1'b1;
        end
      end
    end
  end

  assign pins.txd = txd_q;
  assign pins.sleep_control_low = (st_q != CXM_CTL_OFF);
  assign pins.role_select = role_q;
  assign pins.ctl_clk_oe = ~role_q & ~clk_q;
  assign awake = (st_q != CXM_CTL_OFF);
endmodule

// ===== cxm_link_chk.sv
`timescale 1ns/100ps
module cxm_link_chk
  import cxm_pkg::*;
#(
  parameter int MODE_CHG_CYCLES = MODE_CHG_CYC,
  parameter int ACT_CLKS = ACT_CLOCKS
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic txd,
  input wire logic sleep_control_low,
  input wire logic role_select,
  input wire logic dev_rxd_oe,
  input wire logic dev_clk_oe,
  input wire logic ctl_clk_oe,
  input wire logic rxd_line,
  input wire logic clk_line,
  input wire logic bus_oe,
  input wire logic bus_error,
  input wire cxm_mode_t mode
);
  // ****************************************
  // Helper counters
  // ****************************************
  logic [15:0] stby_q;
  logic [7:0] rise_q;
  logic clk_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stby_q <= 16'h0000;
    end else if (mode == CXM_STANDBY) begin
      stby_q <= stby_q + 16'h0001;
    end else begin
      stby_q <= 16'h0000;
    end
  end

  // Raw clock edges lead the design's synchronised ones, so this count is never behind
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clk_q <= 1'b1;
      rise_q <= 8'h00;
    end else begin
      clk_q <= clk_line;
      if (mode != CXM_NORMAL) begin
        rise_q <= 8'h00;
      end else if (clk_line && !clk_q && rise_q != 8'hff) begin
        rise_q <= rise_q + 8'h01;
      end
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_wake_edge;
    $rose(sleep_control_low) && mode == CXM_SLEEP;
  endsequence
  sequence s_standby_soon;
    ##[1:4] mode == CXM_STANDBY;
  endsequence

  a_reset_sleep: assert property ($fell(reset) |-> (mode == CXM_SLEEP && !bus_oe) [*3])
    else $error("mode after reset is not sleep");
  a_drv_off: assert property (!sleep_control_low |-> !bus_oe)
    else $error("bus driven while sleep control low");
  a_sleep_entry: assert property ($fell(sleep_control_low) |-> txd && clk_line)
    else $error("sleep entered with transmit or clock low");
  a_low_is_sleep: assert property (!sleep_control_low [*5] |-> mode == CXM_SLEEP)
    else $error("sleep control low but not in sleep");
  a_wake_standby: assert property (s_wake_edge |-> s_standby_soon)
    else $error("standby not reached after wake");
  a_stby_quiet: assert property (mode == CXM_STANDBY |-> !bus_oe && !dev_rxd_oe && !dev_clk_oe)
    else $error("drive seen in standby");
  a_stby_source: assert property ($changed(mode) && mode == CXM_STANDBY |->
      $past(mode) == CXM_SLEEP)
    else $error("standby entered from a mode other than sleep");
  a_stby_length: assert property (mode == CXM_NORMAL && $past(mode) == CXM_STANDBY |->
      stby_q >= MODE_CHG_CYCLES - 1 && stby_q <= MODE_CHG_CYCLES + 1)
    else $error("standby length wrong");
  a_act_delay: assert property (mode == CXM_NORMAL && !role_select && bus_oe |->
      rise_q >= ACT_CLKS)
    else $error("master bus drive before activation count");
  a_master_clk_in: assert property (mode == CXM_NORMAL && !role_select |-> !dev_clk_oe)
    else $error("master drives clock pin");
  a_err_sleep: assert property (bus_error && mode != CXM_SLEEP |-> ##[1:3] mode == CXM_SLEEP)
    else $error("bus error did not force sleep");
  a_slave_ctl_quiet: assert property (role_select |-> !ctl_clk_oe)
    else $error("controller drives clock line as slave");
  a_slave_rxd_high: assert property (mode == CXM_SLEEP && $past(mode) == CXM_SLEEP && role_select
      |-> rxd_line)
    else $error("slave receive output low in sleep");
endmodule

// ===== cxm_transceiver_mode_control_tb.sv
`timescale 1ns/100ps
module cxm_transceiver_mode_control_tb;
  import cxm_pkg::*;
  localparam int MCH = 50;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic bus_pull = 1'b0;
  logic bus_error = 1'b0;
  logic role_cfg = 1'b0;
  logic supply_ok = 1'b0;
  logic wake_req = 1'b0;
  logic sleep_req = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic bus_i;
  logic bus_o;
  logic bus_oe;
  logic tx_ready;
  logic [7:0] rx_data;
  logic [7:0] rx_last = 8'h00;
  logic rx_valid;
  logic awake;
  cxm_mode_t mode;
  int mismatches = 0;
  int cmp_count = 0;

  always #5 mclk = ~mclk;
  // Keeps the last byte handed up, so a one-cycle pulse inside a busy task is not missed
  always @(posedge mclk) begin
    if (rx_valid) begin
      rx_last <= rx_data;
    end
  end
  // Pulled-up bus: the transceiver or the bench may pull it low
  assign bus_i = ~(bus_oe | bus_pull);

  cxm_if link();
  cxm_transceiver #(.MODE_CHG_CYCLES(MCH), .ACT_CLKS(ACT_CLOCKS)) cxm_transceiver_inst (
    .mclk(mclk), .reset(reset), .pins(link), .bus_i(bus_i), .bus_o(bus_o),
    .bus_oe(bus_oe), .bus_error(bus_error), .mode(mode));
  cxm_controller #(.BAUD_HALF(40), .SLP_WT_CYCLES(20)) cxm_controller_inst (
    .mclk(mclk), .reset(reset), .pins(link), .role_cfg(role_cfg), .supply_ok(supply_ok),
    .wake_req(wake_req), .sleep_req(sleep_req), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .awake(awake));
  cxm_link_chk #(.MODE_CHG_CYCLES(MCH), .ACT_CLKS(ACT_CLOCKS)) cxm_link_chk_inst (
    .mclk(mclk), .reset(reset), .txd(link.txd), .sleep_control_low(link.sleep_control_low),
    .role_select(link.role_select), .dev_rxd_oe(link.dev_rxd_oe),
    .dev_clk_oe(link.dev_clk_oe), .ctl_clk_oe(link.ctl_clk_oe), .rxd_line(link.rxd_line),
    .clk_line(link.clk_line), .bus_oe(bus_oe), .bus_error(bus_error), .mode(mode));

  // ****************************************
  // Compare and finish
  // ****************************************
  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %b seen %b", n, e, g);
      mismatches++;
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic chk_mode(input string n, input cxm_mode_t e, input cxm_mode_t g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %b seen %b", n, e, g);
      mismatches++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    @(negedge mclk);
    chk_mode("mode", CXM_SLEEP, mode);
    chk_bit("awake", 1'b0, awake);
    chk_bit("bus_oe", 1'b0, bus_oe);
    chk_bit("bus_o", 1'b0, bus_o);
    $display("test reset done");
  endtask

  task automatic t_pull(input logic slave);
    @(posedge mclk);
    bus_pull <= 1'b1;
    repeat (6) @(negedge mclk);
    chk_bit("role_select", slave, link.role_select);
    chk_bit("rxd in sleep", slave, link.rxd_line);
    chk_bit("clk in sleep", ~slave, link.clk_line);
    @(posedge mclk);
    bus_pull <= 1'b0;
    repeat (6) @(negedge mclk);
    chk_bit("rxd idle", 1'b1, link.rxd_line);
    $display("test sleep pass done");
  endtask

  task automatic t_wake();
    int n;
    int r;
    logic q;
    logic p;
    @(posedge mclk);
    supply_ok <= 1'b1;
    wake_req <= 1'b1;
    n = 0;
    while (mode !== CXM_STANDBY && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk_mode("mode", CXM_STANDBY, mode);
    n = 0;
    q = 1'b0;
    while (mode === CXM_STANDBY && n < 1000) begin
      q = q | bus_oe | link.dev_rxd_oe;
      @(negedge mclk);
      n++;
    end
    chk_bit("standby quiet", 1'b0, q);
    chk_bit("standby length", 1'b1, n >= MCH - 1 && n <= MCH + 1);
    chk_mode("mode", CXM_NORMAL, mode);
    r = 0;
    n = 0;
    p = link.clk_line;
    while (bus_oe !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      if (link.clk_line && !p) begin
        r++;
      end
      p = link.clk_line;
      n++;
    end
    chk_bit("activation count", 1'b1, r == ACT_CLOCKS);
    $display("test wake done");
  endtask

  task automatic t_bytes();
    logic [7:0] tbl [4] = '{8'ha5, 8'h3c, 8'h00, 8'hff};
    int n;
    foreach (tbl[i]) begin
      @(posedge mclk);
      tx_data <= tbl[i];
      tx_valid <= 1'b1;
      n = 0;
      @(negedge mclk);
      while (tx_ready !== 1'b1 && n < 3000) begin
        @(negedge mclk);
        n++;
      end
      chk_bit("tx_ready", 1'b1, tx_ready);
      @(posedge mclk);
      tx_valid <= 1'b0;
      n = 0;
      while (link.rxd_line !== 1'b0 && n < 3000) begin
        @(negedge mclk);
        n++;
      end
      chk_bit("start bit", 1'b0, link.rxd_line);
      while (rx_valid !== 1'b1 && n < 3000) begin
        @(negedge mclk);
        n++;
      end
      chk_byte("rx byte", tbl[i], rx_data);
    end
    $display("test bytes done");
  endtask

  task automatic t_error();
    @(posedge mclk);
    bus_error <= 1'b1;
    repeat (4) @(negedge mclk);
    chk_mode("mode", CXM_SLEEP, mode);
    chk_bit("bus_oe", 1'b0, bus_oe);
    @(posedge mclk);
    bus_error <= 1'b0;
    $display("test bus error done");
  endtask

  task automatic t_sleep();
    int n;
    @(posedge mclk);
    wake_req <= 1'b0;
    sleep_req <= 1'b1;
    n = 0;
    while (awake !== 1'b0 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    chk_bit("txd", 1'b1, link.txd);
    chk_bit("clock stopped high", 1'b1, link.clk_line);
    repeat (6) @(negedge mclk);
    chk_mode("mode", CXM_SLEEP, mode);
    @(posedge mclk);
    sleep_req <= 1'b0;
    role_cfg <= 1'b1;
    repeat (10) @(negedge mclk);
    $display("test sleep done");
  endtask

  // Bench plays the bus master: one bit every 16 cycles, low a quarter or a half
  task automatic slave_bit(input logic b, input logic c);
    int k;
    bus_pull <= 1'b1;
    for (k = 1; k <= 16; k++) begin
      @(negedge mclk);
      if (c && k == 7) begin
        chk_bit("slave clk low", 1'b0, link.clk_line);
      end
      if (c && k == 14) begin
        chk_bit("slave clk high", 1'b1, link.clk_line);
      end
      @(posedge mclk);
      if (k == (b ? 4 : 8)) begin
        bus_pull <= 1'b0;
      end
    end
  endtask

  task automatic t_slave();
    int n;
    logic [9:0] frame;
    @(posedge mclk);
    wake_req <= 1'b1;
    n = 0;
    while (mode !== CXM_NORMAL && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk_mode("slave mode", CXM_NORMAL, mode);
    chk_bit("slave role", 1'b1, link.role_select);
    @(posedge mclk);
    // First bit only sets up the period measurement
    slave_bit(1'b1, 1'b0);
    slave_bit(1'b1, 1'b1);
    frame = {1'b1, 8'h96, 1'b0};
    for (n = 0; n < 10; n++) begin
      slave_bit(frame[n], 1'b1);
    end
    slave_bit(1'b1, 1'b1);
    chk_byte("slave rx byte", 8'h96, rx_last);
    $display("test slave done");
  endtask

  initial begin
    #500000;
    mismatches++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    repeat (10) @(posedge mclk);
    t_pull(1'b0);
    t_wake();
    t_bytes();
    t_error();
    t_sleep();
    t_pull(1'b1);
    t_slave();
    conclude();
  end
endmodule
